/* File: rcsb_regs.svh */
`ifndef RCSB_REGS_SVH
`define RCSB_REGS_SVH

// Register byte offsets on the APB port
`define RCSB_OFF_CTRL      8'h00
`define RCSB_OFF_WORK      8'h04
`define RCSB_OFF_FLAGS     8'h08
`define RCSB_OFF_MEMPTR    8'h0C
`define RCSB_OFF_MEMDATA   8'h10
`define RCSB_OFF_STATUS    8'h14

// Control word fields
`define RCSB_CTRL_OP_LSB   0
`define RCSB_CTRL_ADR_LSB  8
`define RCSB_CTRL_IMM_LSB  16

// Flag register bit positions
`define RCSB_FLG_C         0
`define RCSB_FLG_NIB       1
`define RCSB_FLG_Z         2
`define RCSB_FLG_WRAP      3
`define RCSB_FLG_SLT       4
`define RCSB_FLG_NIL       5

// Reset values
`define RCSB_RST_WORK      8'h00
`define RCSB_RST_FLAGS     6'h00

// Data memory size in bytes
`define RCSB_MEM_DEPTH     16

`endif

/* File: rcsb_pkg.sv */
package rcsb_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0]
    {
        RCSB_IDLE = 3'h1,
        RCSB_READ = 3'h2,
        RCSB_EXEC = 3'h4
    } rcsb_state_t;

    // Operation select written into the control word
    typedef enum logic [1:0]
    {
        RCSB_OP_ROTR    = 2'h0,  // rotate_right_thru_borrow_to_work
        RCSB_OP_SUBB_MEM   = 2'h1,  // subtract_with_borrow, memory operand
        RCSB_OP_SUBB_IMM   = 2'h2,  // subtract_with_borrow, literal operand
        RCSB_OP_SUBB_TOMEM = 2'h3   // subtract_with_borrow_to_memory
    } rcsb_op_t;

endpackage

/* File: rcsb_mem_if.sv */
interface rcsb_mem_if #(
    parameter int AW = 4
);
    logic [AW-1:0] addr;    // Byte address
    logic [7:0]    wrData;  // Write byte
    logic          wrEn;    // Write strobe
    logic          rdEn;    // Read strobe, data valid next cycle
    logic [7:0]    rdData;  // Registered read byte

    modport ctrl
    (
        output addr,
        output wrData,
        output wrEn,
        output rdEn,
        input  rdData
    );

    modport mem
    (
        input  addr,
        input  wrData,
        input  wrEn,
        input  rdEn,
        output rdData
    );
endinterface

/* File: rcsb_data_mem.sv */
`include "rcsb_regs.svh"

module rcsb_data_mem #(
    parameter int DEPTH = `RCSB_MEM_DEPTH,
    parameter int AW    = 4
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    rcsb_mem_if.mem  port
);

    logic [7:0] store [DEPTH];   // Byte array, no reset so it maps onto RAM
    logic [7:0] rdData_r;        // Read register

    // Array write; content is undefined until software fills it
    always_ff @(posedge ref_clk)
    begin
        if (port.wrEn)
            store[port.addr] <= port.wrData;
    end

    // Read data leaves through a register, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdData_r <= 8'h00;
        else if (port.rdEn)
            rdData_r <= store[port.addr];
    end

    assign port.rdData = rdData_r;

endmodule

/* File: rcsb_alu_top.sv */
// Summary of operation
// - Rotate right: bit0 to carry, carry to bit7
// - Rotated byte lands in work register
// - Rotate keeps memory; only carry flag changes
// - Memory form: work minus byte minus borrow
// - Carry clear when negative, set otherwise
// - Subtracts update six status flags
// - Literal form subtracts literal and borrow
// - To-memory form writes difference into memory
`include "rcsb_regs.svh"

module rcsb_alu_top #(
    parameter int MEM_DEPTH = `RCSB_MEM_DEPTH
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    rcsb_mem_if #(.AW(AW)) memBus ();   // Link to the data memory

    rcsb_data_mem #(
        .DEPTH (MEM_DEPTH),
        .AW    (AW)
    ) dataMem (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .port    (memBus)
    );

    // State
    rcsb_pkg::rcsb_state_t state_r;     // Sequencer state
    rcsb_pkg::rcsb_op_t    opcode_r;    // Operation latched from control word
    logic [AW-1:0]         opAddr_r;    // Operand byte address
    logic [7:0]            imm_r;       // Literal operand
    logic [7:0]            work_r;      // work_register
    logic [5:0]            flags_r;     // Status flags
    logic [AW-1:0]         ptr_r;       // Software window pointer into memory
    logic                  memWait_r;   // APB read of memory in flight
    logic [7:0]            doneCnt_r;   // Completed operations, wraps
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;

    // APB decode
    wire logic apbAccess = psel & penable & ~pready_r;
    wire logic fsmIdle   = (state_r == rcsb_pkg::RCSB_IDLE);
    // Requests wait while an operation runs so software never races the datapath
    wire logic canServe  = apbAccess & fsmIdle & ~memWait_r;
    wire logic hitCtrl   = (paddr == `RCSB_OFF_CTRL);
    wire logic hitWork   = (paddr == `RCSB_OFF_WORK);
    wire logic hitFlags  = (paddr == `RCSB_OFF_FLAGS);
    wire logic hitPtr    = (paddr == `RCSB_OFF_MEMPTR);
    wire logic hitData   = (paddr == `RCSB_OFF_MEMDATA);
    wire logic hitStat   = (paddr == `RCSB_OFF_STATUS);
    wire logic anyHit    = hitCtrl | hitWork | hitFlags | hitPtr | hitData | hitStat;
    wire logic wrStrobe  = canServe & pwrite;
    wire logic memRdReq  = canServe & ~pwrite & hitData;
    wire logic startOp   = wrStrobe & hitCtrl;

    // Operand selection
    wire logic       carryIn  = flags_r[`RCSB_FLG_C];
    wire logic       borrowIn = ~carryIn;
    wire logic       useImm   = (opcode_r == rcsb_pkg::RCSB_OP_SUBB_IMM);
    wire logic       isRot    = (opcode_r == rcsb_pkg::RCSB_OP_ROTR);
    wire logic       toMem    = (opcode_r == rcsb_pkg::RCSB_OP_SUBB_TOMEM);
    wire logic [7:0] operand  = useImm ? imm_r : memBus.rdData;

    // Full-precision difference; bit 8 is the borrow out
    wire logic [8:0] fullDiff = {1'h0, work_r} - {1'h0, operand} - {8'h00, borrowIn};
    wire logic [4:0] nibDiff  = {1'h0, work_r[3:0]} - {1'h0, operand[3:0]} - {4'h0, borrowIn};
    wire logic [7:0] diff     = fullDiff[7:0];
    wire logic       diffZero = (diff == 8'h00);
    // Overflow when signs of inputs differ and result sign leaves the minuend's
    wire logic       ovNew    = (work_r[7] ^ operand[7]) & (work_r[7] ^ diff[7]);

    // Six-flag result of any subtract
    logic [5:0] subFlags;
    always_comb
    begin
        subFlags                 = 6'h00;
        subFlags[`RCSB_FLG_C]    = ~fullDiff[8];
        subFlags[`RCSB_FLG_NIB]  = ~nibDiff[4];
        subFlags[`RCSB_FLG_Z]    = diffZero;
        subFlags[`RCSB_FLG_WRAP] = ovNew;
        subFlags[`RCSB_FLG_SLT]  = diff[7] ^ ovNew;
        // Multi-byte zero only survives if every earlier byte was zero too
        subFlags[`RCSB_FLG_NIL]  = diffZero & flags_r[`RCSB_FLG_NIL];
    end

    // Rotate: bits 0..6 from memory bits 1..7, old carry into bit 7
    logic [7:0] rotated;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_rot
            assign rotated[gi] = memBus.rdData[gi + 1];
        end
    endgenerate
    assign rotated[7] = carryIn;

    wire logic inExec = (state_r == rcsb_pkg::RCSB_EXEC);

    // Memory port: the sequencer owns it while busy, APB otherwise
    assign memBus.addr   = fsmIdle ? ptr_r : opAddr_r;
    assign memBus.wrData = fsmIdle ? pwdata[7:0] : diff;
    // Rotate never writes memory; only the to-memory form does
    assign memBus.wrEn   = (inExec & toMem) | (wrStrobe & hitData);
    assign memBus.rdEn   = (state_r == rcsb_pkg::RCSB_READ) | memRdReq;

    // Register read mux
    wire logic [31:0] readMux =
        hitCtrl  ? {8'h00, imm_r, {(8 - AW){1'h0}}, opAddr_r, 6'h00, opcode_r} :
        hitWork  ? {24'h000000, work_r} :
        hitFlags ? {26'h0000000, flags_r} :
        hitPtr   ? {{(32 - AW){1'h0}}, ptr_r} :
        hitStat  ? {24'h000000, doneCnt_r} :
                   32'h00000000;

    // Sequencer: idle -> read operand byte -> execute
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= rcsb_pkg::RCSB_IDLE;
        else
        begin
            case (state_r)
                rcsb_pkg::RCSB_IDLE:
                    if (startOp)
                        state_r <= rcsb_pkg::RCSB_READ;
                rcsb_pkg::RCSB_READ:
                    state_r <= rcsb_pkg::RCSB_EXEC;
                rcsb_pkg::RCSB_EXEC:
                    state_r <= rcsb_pkg::RCSB_IDLE;
                default:
                    state_r <= rcsb_pkg::RCSB_IDLE;
            endcase
        end
    end

    // Control word capture
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opcode_r <= rcsb_pkg::RCSB_OP_ROTR;
            opAddr_r <= '0;
            imm_r    <= 8'h00;
        end
        else if (startOp)
        begin
            opcode_r <= rcsb_pkg::rcsb_op_t'(pwdata[`RCSB_CTRL_OP_LSB +: 2]);
            opAddr_r <= pwdata[`RCSB_CTRL_ADR_LSB +: AW];
            imm_r    <= pwdata[`RCSB_CTRL_IMM_LSB +: 8];
        end
    end

    // Work register: software write, or result of rotate / subtract
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            work_r <= `RCSB_RST_WORK;
        else if (inExec & isRot)
            work_r <= rotated;
        else if (inExec & ~toMem)
            work_r <= diff;
        else if (wrStrobe & hitWork)
            work_r <= pwdata[7:0];
    end

    // Flags: rotate touches carry alone, subtracts load all six
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_r <= `RCSB_RST_FLAGS;
        else if (inExec & isRot)
            flags_r[`RCSB_FLG_C] <= memBus.rdData[0];
        else if (inExec)
            flags_r <= subFlags;
        else if (wrStrobe & hitFlags)
            flags_r <= pwdata[5:0];
    end

    // Window pointer and completion count
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_r     <= '0;
            doneCnt_r <= 8'h00;
        end
        else
        begin
            if (wrStrobe & hitPtr)
                ptr_r <= pwdata[AW-1:0];
            if (inExec)
                doneCnt_r <= doneCnt_r + 8'h01;
        end
    end

    // APB answer; memory reads need one extra cycle for the registered byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memWait_r <= 1'h0;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
        end
        else
        begin
            memWait_r <= memRdReq;
            pready_r  <= (canServe & ~memRdReq) | memWait_r;
            pslverr_r <= canServe & ~anyHit;
            if (memWait_r)
                prdata_r <= {24'h000000, memBus.rdData};
            else if (canServe & ~pwrite)
                prdata_r <= readMux;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

endmodule

/* File: rcsb_alu_props.sv */
module rcsb_alu_props
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so default clocking keeps each property short
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Off the six words or misaligned
    wire logic badA = paddr > 8'h14 || paddr[1:0] != 2'h0;
    // Memory reads take one extra cycle
    wire logic memRd = paddr == 8'h10 && !pwrite;
    property p_rdyPulse; pready |=> !pready; endproperty
    a_rdyPulse: assert property (p_rdyPulse) else $error("ready wider than one cycle");
    property p_rdyAcc; pready |-> psel && penable; endproperty
    a_rdyAcc: assert property (p_rdyAcc) else $error("ready outside access phase");
    property p_errRdy; pslverr |-> pready; endproperty
    a_errRdy: assert property (p_errRdy) else $error("error without ready");
    property p_errBad; pready |-> pslverr == badA; endproperty
    a_errBad: assert property (p_errBad) else $error("error flag wrong for address");
    property p_badZero; pready && !pwrite && badA |-> prdata == 32'h0; endproperty
    a_badZero: assert property (p_badZero) else $error("unmapped read not zero");
    property p_upper; pready && !pwrite && paddr != 8'h00 |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_regLat; $rose(penable) && !memRd |=> pready; endproperty
    a_regLat: assert property (p_regLat) else $error("register answer late");
    property p_memLat; $rose(penable) && memRd |=> !pready ##1 pready; endproperty
    a_memLat: assert property (p_memLat) else $error("memory read answer timing");
    c_ctrl: cover property (pready && pwrite && paddr == 8'h00);
    c_mem: cover property (pready && memRd);
    c_err: cover property (pslverr);
endmodule

/* File: rcsb_core_host.sv */
// Stands in for the core decoder: issues APB transfers, waits for ready
module rcsb_core_host
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero
    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request is left up so the next setup follows at once; idle drops it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // No fixed latency assumed; the bench watchdog ends a hang
        do @(posedge ref_clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
    endtask
    task automatic idle;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask
endmodule

/* File: rcsb_alu_top_test.sv */
module rcsb_alu_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    int          errors = 0;
    int          num_checks = 0;
    int          seed = 54298;
    // Reference state: work, flags, memory byte, carry, operand, difference
    int          w, f, m, c, o, d, r, v, op, adr, lit;
    initial forever #12.5 ref_clk = ~ref_clk;
    rcsb_alu_top #(.MEM_DEPTH(16)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rcsb_core_host HOST (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input int x);
        HOST.xfer(1'h1, a, x, q, e);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input int x);
        HOST.xfer(1'h0, a, 32'h0, q, e);
        chk(n, x, q);
    endtask
    task automatic wrap_up;
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Run needs about 1200 cycles; sixteen times that is a hang
    initial
    begin
        #500000;
        errors++;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        wr(8'h18, 32'hFF);
        chk("badErr", 1, e);
        rd("work", 8'h04, 0);
        rd("flags", 8'h08, 0);
        for (int i = 0; i < 48; i++)
        begin
            op = i % 4;
            adr = $random(seed) & 15;
            lit = $random(seed) & 255;
            w = $random(seed) & 255;
            f = $random(seed) & 63;
            m = $random(seed) & 255;
            // Early passes force wrap below zero and an exact zero
            if (i < 8)
                m = (i < 4) ? 255 : w;
            c = f & 1;
            wr(8'h04, w);
            wr(8'h08, f);
            wr(8'h0C, adr);
            wr(8'h10, m);
            wr(8'h00, op | adr << 8 | lit << 16);
            if (op == 0)
            begin
                w = (c << 7) | (m >> 1);
                f = (f & 62) | (m & 1);
            end
            else
            begin
                o = (op == 2) ? lit : m;
                d = w - o - 1 + c;
                r = d & 255;
                v = (((w ^ o) & (w ^ r)) >> 7) & 1;
                f = int'(d >= 0) | int'((w & 15) - (o & 15) - 1 + c >= 0) << 1 | int'(r == 0) << 2
                    | v << 3 | ((r >> 7) ^ v) << 4 | (int'(r == 0) & (f >> 5)) << 5;
                if (op == 3)
                    m = r;
                else
                    w = r;
            end
            rd("work", 8'h04, w);
            rd("flags", 8'h08, f);
            rd("mem", 8'h10, m);
        end
        rd("count", 8'h14, 48);
        HOST.idle;
        wrap_up;
    end
endmodule
bind rcsb_alu_top rcsb_alu_props PROPS (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
